// ### hdl/mcs_pkg.sv
package mcs_pkg;
	localparam int          PHASE_DIV     = 2;
	localparam int          PHASE_W       = 1;
	localparam logic        SEL_RST       = 1'h0;
	localparam logic [PHASE_W-1:0] PHASE_RST = 1'h0;
	localparam logic        VALID_RST     = 1'h1;
	localparam int          SYNC_STAGES   = 2;
	localparam int          SYNC_WIDTH    = 4;
	localparam int          IDX_SCLK      = 0;
	localparam int          IDX_SE        = 1;
	localparam int          IDX_DP        = 2;
	localparam int          IDX_DN        = 3;
endpackage : mcs_pkg

// ### hdl/mcs_sync2.sv
`timescale 1ns/10ps
module mcs_sync2 #(
	parameter int WIDTH = mcs_pkg::SYNC_WIDTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} mcs_sync_s;

	mcs_sync_s st;
	mcs_sync_s next_st;

	// First stage feeds only the second; nothing else looks at it
	always_comb begin
		next_st        = st;
		next_st.meta   = async_in;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stable;
endmodule : mcs_sync2

// ### hdl/mcs_sample_sync.sv
`timescale 1ns/10ps
module mcs_sample_sync #(
	parameter int PHASE_DIV = mcs_pkg::PHASE_DIV
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        sample_clk,
	input  wire logic                        sample_sync_reset,
	input  wire logic                        sample_sync_reset_p,
	input  wire logic                        sample_sync_reset_n,
	input  wire logic                        select_write,
	input  wire logic                        select_value,
	output logic                             diff_sync_reset_select,
	output logic [mcs_pkg::PHASE_W-1:0]      sample_phase,
	output logic                             data_valid,
	output logic                             sync_active,
	output logic                             realign_pulse
);
	typedef struct packed {
		logic                        sel;
		logic                        sclk_d;
		logic                        active;
		logic                        armed;
		logic                        valid;
		logic                        realign;
		logic [mcs_pkg::PHASE_W-1:0] phase;
	} mcs_state_s;

	mcs_state_s st;
	mcs_state_s next_st;
	logic [mcs_pkg::SYNC_WIDTH-1:0] raw;
	logic [mcs_pkg::SYNC_WIDTH-1:0] syn;
	logic                           sclk_s;
	logic                           se_s;
	logic                           diff_s;
	logic                           rst_now;
	logic                           sclk_fall;

	// Local alias keeps every size cast on a plain name; the width itself stays in the package
	localparam int PW = mcs_pkg::PHASE_W;

	function automatic logic [PW-1:0] phase_step(input logic [PW-1:0] p);
		logic [PW-1:0] last;
		last = PW'(PHASE_DIV - 1);
		return (p == last) ? mcs_pkg::PHASE_RST : PW'(p + 1'h1);
	endfunction : phase_step

	assign raw[mcs_pkg::IDX_SCLK] = sample_clk;
	assign raw[mcs_pkg::IDX_SE]   = sample_sync_reset;
	assign raw[mcs_pkg::IDX_DP]   = sample_sync_reset_p;
	assign raw[mcs_pkg::IDX_DN]   = sample_sync_reset_n;

	// All pins cross together so the release and the sample edge keep their skew
	mcs_sync2 #(
		.WIDTH    (mcs_pkg::SYNC_WIDTH)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (raw),
		.sync_out (syn)
	);

	assign sclk_s    = syn[mcs_pkg::IDX_SCLK];
	assign se_s      = syn[mcs_pkg::IDX_SE];
	assign diff_s    = syn[mcs_pkg::IDX_DP] & ~syn[mcs_pkg::IDX_DN];
	assign rst_now   = st.sel ? diff_s : se_s;
	assign sclk_fall = st.sclk_d & ~sclk_s;

	always_comb begin
		next_st         = st;
		next_st.sclk_d  = sclk_s;
		next_st.realign = 1'h0;
		if (select_write) begin
			next_st.sel = select_value;
		end
		if (rst_now) begin
			next_st.active = 1'h1;
			next_st.armed  = 1'h0;
			next_st.valid  = 1'h0;
			next_st.phase  = mcs_pkg::PHASE_RST;
		end else if (st.active && !st.armed) begin
			// Release seen; wait for the falling edge that follows it
			next_st.armed = 1'h1;
		end else if (st.armed && sclk_fall) begin
			next_st.armed   = 1'h0;
			next_st.active  = 1'h0;
			next_st.valid   = 1'h1;
			next_st.realign = 1'h1;
			next_st.phase   = mcs_pkg::PHASE_RST;
		end else if (!st.active && sclk_fall) begin
			next_st.phase = phase_step(st.phase);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st        <= '0;
			st.sel    <= mcs_pkg::SEL_RST;
			st.valid  <= mcs_pkg::VALID_RST;
			st.phase  <= mcs_pkg::PHASE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign diff_sync_reset_select = st.sel;
	assign sample_phase           = st.phase;
	assign data_valid             = st.valid;
	assign sync_active            = st.active;
	assign realign_pulse          = st.realign;

	property p_sel_reset;
		@(posedge clk) rst |=> (diff_sync_reset_select == 1'h0);
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");

	property p_source;
		@(posedge clk) disable iff (rst)
		(st.sel ? (diff_s && !se_s) : (se_s && !diff_s)) |=> (sync_active && !data_valid);
	endproperty
	a_source: assert property (p_source) else $error("selected sync reset source ignored");

	property p_wrong_source;
		@(posedge clk) disable iff (rst)
		(!st.active && !(st.sel ? diff_s : se_s) && (st.sel ? se_s : diff_s)) |=> !sync_active;
	endproperty
	a_wrong_source: assert property (p_wrong_source) else $error("unselected source took effect");

	property p_hold;
		@(posedge clk) disable iff (rst)
		rst_now |=> (sample_phase == mcs_pkg::PHASE_RST && !data_valid && !realign_pulse);
	endproperty
	a_hold: assert property (p_hold) else $error("divider not held during sync reset");

	property p_any_time;
		@(posedge clk) disable iff (rst)
		(rst_now && !sclk_fall) |=> sync_active;
	endproperty
	a_any_time: assert property (p_any_time) else $error("unaligned sync reset missed");

	sequence s_release;
		st.active && !st.armed && !rst_now;
	endsequence

	sequence s_armed_fall;
		st.armed && sclk_fall && !rst_now;
	endsequence

	property p_arm;
		@(posedge clk) disable iff (rst)
		s_release |=> (st.armed && sync_active);
	endproperty
	a_arm: assert property (p_arm) else $error("release not armed");

	property p_realign;
		@(posedge clk) disable iff (rst)
		s_armed_fall |=> (realign_pulse && data_valid && sample_phase == mcs_pkg::PHASE_RST) ##1 !realign_pulse;
	endproperty
	a_realign: assert property (p_realign) else $error("no realign on following fall");

	property p_no_early;
		@(posedge clk) disable iff (rst)
		(st.armed && !sclk_fall) |=> !realign_pulse;
	endproperty
	a_no_early: assert property (p_no_early) else $error("realign before falling edge");

	property p_count;
		@(posedge clk) disable iff (rst)
		(!st.active && sclk_fall && !rst_now) |=> (sample_phase == phase_step($past(sample_phase)));
	endproperty
	a_count: assert property (p_count) else $error("phase divider did not advance");

	property p_sel_write;
		@(posedge clk) disable iff (rst)
		select_write |=> (diff_sync_reset_select == $past(select_value));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("selection write not taken");

	property p_sel_keep;
		@(posedge clk) disable iff (rst)
		!select_write |=> $stable(diff_sync_reset_select);
	endproperty
	a_sel_keep: assert property (p_sel_keep) else $error("selection changed without a write");

	// Busy and valid never stand together, and the divider sits at its start while busy
	property p_not_valid_busy;
		@(posedge clk) disable iff (rst)
		sync_active |-> (!data_valid && sample_phase == mcs_pkg::PHASE_RST);
	endproperty
	a_not_valid_busy: assert property (p_not_valid_busy) else $error("data valid while sync busy");

	property p_busy_keep;
		@(posedge clk) disable iff (rst)
		(sync_active && !(st.armed && sclk_fall && !rst_now)) |=> sync_active;
	endproperty
	a_busy_keep: assert property (p_busy_keep) else $error("sync busy dropped before realign");

	property p_valid_keep;
		@(posedge clk) disable iff (rst)
		(data_valid && !rst_now) |=> data_valid;
	endproperty
	a_valid_keep: assert property (p_valid_keep) else $error("data valid dropped without sync reset");

	property p_phase_still;
		@(posedge clk) disable iff (rst)
		(!sclk_fall && !rst_now) |=> $stable(sample_phase);
	endproperty
	a_phase_still: assert property (p_phase_still) else $error("phase moved without a sample fall");

	property p_realign_origin;
		@(posedge clk) disable iff (rst)
		realign_pulse |-> ($past(st.armed) && $past(sclk_fall) && !sync_active);
	endproperty
	a_realign_origin: assert property (p_realign_origin) else $error("realign without armed fall");
endmodule : mcs_sample_sync

// ### testbench/mcs_ctrl_model.sv
`timescale 1ns/10ps
module mcs_ctrl_model (
	input  wire logic go,
	input  wire logic diff,
	input  wire logic wrong,
	output logic      sample_clk,
	output logic      se,
	output logic      dp,
	output logic      dn
);
	initial begin
		sample_clk = 1'h0;
		forever #200 sample_clk = ~sample_clk;
	end
	// Wrong drives the unselected source, so a refusal can be seen
	task automatic drive(input logic v);
		if (diff ^ wrong) begin
			dp = v;
			dn = ~v;
		end else begin
			se = v;
		end
	endtask : drive
	initial begin
		se = 1'h0;
		dp = 1'h0;
		dn = 1'h1;
		forever begin
			@(posedge go);
			#37 drive(1'h1);
			repeat (2) @(posedge sample_clk);
			drive(1'h0);
		end
	end
endmodule : mcs_ctrl_model

// ### testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic clk, rst, go, diff, wrong, sel_wr, sc, se, dp, dn, sel_q, valid, active, realign;
	logic [mcs_pkg::PHASE_W-1:0] phase;
	int num_errors = 0;
	int tests_run = 0;
	mcs_sample_sync DUT (.clk(clk), .rst(rst), .sample_clk(sc), .sample_sync_reset(se),
		.sample_sync_reset_p(dp), .sample_sync_reset_n(dn), .select_write(sel_wr), .select_value(diff),
		.diff_sync_reset_select(sel_q), .sample_phase(phase), .data_valid(valid), .sync_active(active),
		.realign_pulse(realign));
	mcs_ctrl_model ctrl (.go(go), .diff(diff), .wrong(wrong), .sample_clk(sc), .se(se), .dp(dp), .dn(dn));
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic sync_case(input logic d, input logic w);
		int n;
		diff = d;
		wrong = w;
		sel_wr = 1'h1;
		@(negedge clk);
		sel_wr = 1'h0;
		chk(sel_q === d, "selection readback");
		go = 1'h1;
		n = 0;
		while (active !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		go = 1'h0;
		if (w) begin
			chk(active === 1'b0 && valid === 1'b1, "unselected source acted");
			return;
		end
		chk(valid === 1'b0 && phase === 1'h0, "not held while asserted");
		n = 0;
		while (realign !== 1'b1 && n < 80) begin
			@(negedge clk);
			n++;
		end
		// Sample clock still low proves the falling edge, not the rising one, realigned
		chk(realign === 1'b1 && sc === 1'b0 && valid === 1'b1 && active === 1'b0, "realign");
		@(negedge sc);
		repeat (6) @(negedge clk);
		chk(phase === 1'h1, "phase did not advance from realigned start");
	endtask : sync_case
	initial begin
		rst = 1'h1;
		go = 1'h0;
		diff = 1'h0;
		wrong = 1'h0;
		sel_wr = 1'h0;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		repeat (3) @(negedge clk);
		chk(sel_q === 1'b0 && valid === 1'b1 && active === 1'b0, "reset state");
		for (int i = 0; i < 4; i++)
			sync_case(i[1], i[0]);
		summarize();
	end
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
endmodule : tb_top
